// >>> hw/fail_safe_monitor_defines.svh
/*
 Offsets, field positions, reset values and timing counts of the fail-safe clock monitor.
 Assumes inclusion by bare name from files under hw/.
*/
`ifndef FAIL_SAFE_MONITOR_DEFINES_SVH
`define FAIL_SAFE_MONITOR_DEFINES_SVH
`define FAIL_SAFE_MONITOR_ADDR_W 2
`define FAIL_SAFE_MONITOR_OFS_CTRL 2'h0
`define FAIL_SAFE_MONITOR_OFS_STAT 2'h1
`define FAIL_SAFE_MONITOR_OFS_IEN 2'h2
`define FAIL_SAFE_MONITOR_OFS_IFLG 2'h3
`define FAIL_SAFE_MONITOR_IRCF_MSB 6
`define FAIL_SAFE_MONITOR_IRCF_LSB 3
`define FAIL_SAFE_MONITOR_IRCF_RST 4'h7
`define FAIL_SAFE_MONITOR_SCS_MSB 1
`define FAIL_SAFE_MONITOR_SCS_LSB 0
`define FAIL_SAFE_MONITOR_SCS_RST 2'h0
`define FAIL_SAFE_MONITOR_SECONDARY_OSC_READY_BIT 7
`define FAIL_SAFE_MONITOR_STARTUP_TIMER_STATUS_BIT 5
`define FAIL_SAFE_MONITOR_HFR_BIT 4
`define FAIL_SAFE_MONITOR_LFR_BIT 1
`define FAIL_SAFE_MONITOR_HFS_BIT 0
`define FAIL_SAFE_MONITOR_FAIL_BIT 7
`define FAIL_SAFE_MONITOR_SAMPLE_DIV 64
`define FAIL_SAFE_MONITOR_OST_CYCLES 1024
`endif

// >>> hw/fail_safe_monitor_pkg.sv
/*
 Types shared by the fail-safe clock monitor files.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package fail_safe_monitor_pkg;
    typedef enum logic [2:0]
    {
        FAIL_SAFE_MONITOR_LP = 3'h0,
        FAIL_SAFE_MONITOR_XT = 3'h1,
        FAIL_SAFE_MONITOR_HS = 3'h2,
        FAIL_SAFE_MONITOR_EC = 3'h3,
        FAIL_SAFE_MONITOR_RC = 3'h4,
        FAIL_SAFE_MONITOR_INT = 3'h5
    } fail_safe_monitor_mode_t;
    typedef enum {FAIL_SAFE_MONITOR_ST_INT, FAIL_SAFE_MONITOR_ST_OST, FAIL_SAFE_MONITOR_ST_EXT, FAIL_SAFE_MONITOR_ST_FAIL} fail_safe_monitor_state_t;
endpackage
`default_nettype wire

// >>> hw/fail_safe_monitor_sync.sv
/*
 Two-flip-flop level synchroniser for one pin-side signal.
 Assumes the input is asynchronous to mclk.
*/
`default_nettype none
module fail_safe_monitor_sync
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic meta_r;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> hw/fail_safe_monitor_edge_count.sv
/*
 Counts falling edges of a synchronised clock level; wraps at a settable terminal count.
 Assumes the input already passed a synchroniser.
*/
`default_nettype none
module fail_safe_monitor_edge_count #(parameter int WIDTH = 10)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic clr,
    input wire logic lvl,
    input wire logic [WIDTH-1:0] last,
    output logic fall,
    output logic done
);
    logic prev_r;
    logic [WIDTH-1:0] cnt_r;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            prev_r <= 1'b0;
        else
            prev_r <= lvl;
    end
    assign fall = prev_r && !lvl;
    assign done = fall && (cnt_r == last);
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            cnt_r <= '0;
        else if (clr || done)
            cnt_r <= '0;
        else if (fall)
            cnt_r <= cnt_r + 1'b1;
    end
endmodule
`default_nettype wire

// >>> hw/fail_safe_monitor_top.sv
/*
 Fail-safe clock monitor with oscillator control, status and fail flag registers.
 Assumes oscillator levels arrive from pins unsynchronised and a plain register port
 on mclk; the internal clock switch itself is made by outer logic from the outputs.
*/
// The register addresses and strobed register access were left to the implementer.
// Contract
// - Monitor works only when config enable set, in every external oscillator mode.
// - No failure flagged before the start-up timer has expired.
// - Sample clock is the low-frequency internal oscillator divided by 64.
// - Detector latch set on external falling edge, cleared on sample rising edge.
// - Failure when a whole sample half-period passes without external clock low.
// - On failure move system clock to internal source and set fail flag.
// - Interrupt request when fail flag set and its enable set.
// - Fallback internal frequency is the one in the frequency select field.
// - Clock stays internal after failure until firmware switches back.
// - Fail condition cleared by reset, sleep, or a write changing clock select.
// - Clock select change restarts start-up timer; run internal meanwhile.
// - Persisting failure after switch back sets the fail flag again; here only in EC and RC modes, crystal modes stay in start-up.
// - External clock and RC modes skip the start-up timer.
// - Enabling monitor also enables two-speed start-up.
// - Monitor inactive during oscillator start-up after reset or sleep exit.
// - Frequency select bits 6..3, 1111 is 16 MHz, resets to 0111.
// - Clock select bits 1..0: 1x internal, 01 secondary, 00 configured.
// - Start-up status reads 1 on configured clock, 0 on internal.
// - Secondary ready follows oscillator when enabled, reads 1 when disabled.
// - High-frequency ready at bit 4, low-frequency ready at bit 1.
// - Stable bit is 1 when the 16 MHz oscillator drives the internal clock.
// - Crystal modes count 1024 oscillator cycles before external use.
`include "fail_safe_monitor_defines.svh"
`default_nettype none
module fail_safe_monitor_top #(parameter int OST_CYCLES = `FAIL_SAFE_MONITOR_OST_CYCLES)
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [`FAIL_SAFE_MONITOR_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire fail_safe_monitor_pkg::fail_safe_monitor_mode_t osc_mode_cfg,
    input wire logic fail_monitor_enable_cfg,
    input wire logic sleep_exec,
    input wire logic ext_clk_pin,
    input wire logic lf_osc_pin,
    input wire logic sec_osc_pin,
    input wire logic secondary_osc_enable,
    input wire logic hf_ready_pin,
    input wire logic lf_ready_pin,
    input wire logic hf_stable_pin,
    input wire logic sec_ready_pin,
    output logic sys_on_ext,
    output logic sys_on_sec,
    output logic [3:0] int_freq_sel,
    output logic irq
);
    import fail_safe_monitor_pkg::*;

    localparam int SHALF = `FAIL_SAFE_MONITOR_SAMPLE_DIV / 2;
    localparam logic [9:0] OST_LAST = 10'(OST_CYCLES - 1);

    logic ext_s, lf_s, sec_s, hfr_s, lfr_s, hfs_s, secr_s;
    fail_safe_monitor_sync u_sx (.mclk(mclk), .arst_n(arst_n), .din(ext_clk_pin), .dout(ext_s));
    fail_safe_monitor_sync u_sl (.mclk(mclk), .arst_n(arst_n), .din(lf_osc_pin), .dout(lf_s));
    fail_safe_monitor_sync u_ss (.mclk(mclk), .arst_n(arst_n), .din(sec_osc_pin), .dout(sec_s));
    fail_safe_monitor_sync u_s1 (.mclk(mclk), .arst_n(arst_n), .din(hf_ready_pin), .dout(hfr_s));
    fail_safe_monitor_sync u_s2 (.mclk(mclk), .arst_n(arst_n), .din(lf_ready_pin), .dout(lfr_s));
    fail_safe_monitor_sync u_s3 (.mclk(mclk), .arst_n(arst_n), .din(hf_stable_pin), .dout(hfs_s));
    fail_safe_monitor_sync u_s4 (.mclk(mclk), .arst_n(arst_n), .din(sec_ready_pin), .dout(secr_s));

    logic [3:0] ircf_r;
    logic [1:0] scs_r;
    logic fail_ie_r;
    logic fail_flag_r;
    fail_safe_monitor_state_t st_r;
    logic [7:0] stat_w;

    wire wr_ctrl = reg_wr && reg_addr == `FAIL_SAFE_MONITOR_OFS_CTRL;
    wire [1:0] scs_new = reg_wdata[`FAIL_SAFE_MONITOR_SCS_MSB:`FAIL_SAFE_MONITOR_SCS_LSB];
    wire scs_change = wr_ctrl && scs_new != scs_r;
    wire crystal = osc_mode_cfg inside {FAIL_SAFE_MONITOR_LP, FAIL_SAFE_MONITOR_XT, FAIL_SAFE_MONITOR_HS};
    wire ext_mode = osc_mode_cfg != FAIL_SAFE_MONITOR_INT;
    wire restart = sleep_exec || scs_change;

    // Start-up timer counts external falling edges
    logic ost_done, ext_fall, lf_fall, sec_fall, sec_done;
    fail_safe_monitor_edge_count #(.WIDTH(10)) u_ost
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(restart || st_r != FAIL_SAFE_MONITOR_ST_OST),
        .lvl(ext_s),
        .last(OST_LAST),
        .fall(ext_fall),
        .done(ost_done)
    );

    // Sample clock divider on the low-frequency oscillator
    fail_safe_monitor_edge_count #(.WIDTH(5)) u_div
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(1'b0),
        .lvl(lf_s),
        .last(5'(SHALF - 1)),
        .fall(lf_fall),
        .done(sec_done)
    );
    fail_safe_monitor_edge_count #(.WIDTH(1)) u_sfall
    (
        .mclk(mclk),
        .arst_n(arst_n),
        .clr(1'b0),
        .lvl(sec_s),
        .last(1'b0),
        .fall(sec_fall),
        .done()
    );

    logic samp_r;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            samp_r <= 1'b0;
        else if (sec_done)
            samp_r <= !samp_r;
    end
    wire samp_edge = sec_done;

    // Monitored clock: the secondary oscillator when selected, else the configured one
    wire mon_fall = (scs_r == 2'h1) ? sec_fall : ext_fall;

    // Detector latch, cleared by the rising sample-clock edge; a falling edge with it still clear means failure
    logic seen_r;
    logic armed_r;
    wire det_run = fail_monitor_enable_cfg && st_r == FAIL_SAFE_MONITOR_ST_EXT;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            seen_r <= 1'b0;
        else if (samp_edge && samp_r == 1'b0)
            seen_r <= mon_fall;
        else if (mon_fall)
            seen_r <= 1'b1;
    end
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            armed_r <= 1'b0;
        else if (!det_run)
            armed_r <= 1'b0;
        else if (samp_edge && samp_r == 1'b0)
            armed_r <= 1'b1;
    end
    // Half-period check at falling sample edge; a partial window before the arming rising edge is skipped
    wire fail_det = det_run && armed_r && samp_edge && samp_r && !seen_r && !mon_fall;

    // Clock source state
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= FAIL_SAFE_MONITOR_ST_INT;
        else if (restart)
            st_r <= (sleep_exec || scs_new == 2'h0) ? start_state() : sel_state(scs_new);
        else
        begin
            unique case (st_r)
                FAIL_SAFE_MONITOR_ST_INT:
                    st_r <= FAIL_SAFE_MONITOR_ST_INT;
                FAIL_SAFE_MONITOR_ST_OST:
                    if (ost_done)
                        st_r <= FAIL_SAFE_MONITOR_ST_EXT;
                FAIL_SAFE_MONITOR_ST_EXT:
                    if (fail_det)
                        st_r <= FAIL_SAFE_MONITOR_ST_FAIL;
                FAIL_SAFE_MONITOR_ST_FAIL:
                    st_r <= FAIL_SAFE_MONITOR_ST_FAIL;
            endcase
        end
    end

    function automatic fail_safe_monitor_state_t start_state();
        if (!ext_mode)
            return FAIL_SAFE_MONITOR_ST_INT;
        else if (crystal)
            return FAIL_SAFE_MONITOR_ST_OST;
        else
            return FAIL_SAFE_MONITOR_ST_EXT;
    endfunction

    function automatic fail_safe_monitor_state_t sel_state(input logic [1:0] s);
        if (s[1])
            return FAIL_SAFE_MONITOR_ST_INT;
        else
            return FAIL_SAFE_MONITOR_ST_OST;
    endfunction

    // Reset leaves the state at internal until a sleep exit or select change; boot_r only holds sys_on_ext low for the first cycle
    logic boot_r;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            boot_r <= 1'b1;
        else
            boot_r <= 1'b0;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ircf_r <= `FAIL_SAFE_MONITOR_IRCF_RST;
            scs_r <= `FAIL_SAFE_MONITOR_SCS_RST;
        end
        else if (wr_ctrl)
        begin
            ircf_r <= reg_wdata[`FAIL_SAFE_MONITOR_IRCF_MSB:`FAIL_SAFE_MONITOR_IRCF_LSB];
            scs_r <= scs_new;
        end
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            fail_ie_r <= 1'b0;
        else if (reg_wr && reg_addr == `FAIL_SAFE_MONITOR_OFS_IEN)
            fail_ie_r <= reg_wdata[`FAIL_SAFE_MONITOR_FAIL_BIT];
    end

    // Set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            fail_flag_r <= 1'b0;
        else if (fail_det)
            fail_flag_r <= 1'b1;
        else if (reg_wr && reg_addr == `FAIL_SAFE_MONITOR_OFS_IFLG)
            fail_flag_r <= reg_wdata[`FAIL_SAFE_MONITOR_FAIL_BIT];
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq <= 1'b0;
        else
            irq <= fail_flag_r && fail_ie_r;
    end

    wire on_cfg = st_r == FAIL_SAFE_MONITOR_ST_EXT && scs_r == 2'h0;
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sys_on_ext <= 1'b0;
            sys_on_sec <= 1'b0;
            int_freq_sel <= `FAIL_SAFE_MONITOR_IRCF_RST;
        end
        else
        begin
            sys_on_ext <= on_cfg && !boot_r;
            sys_on_sec <= st_r == FAIL_SAFE_MONITOR_ST_EXT && scs_r == 2'h1;
            int_freq_sel <= ircf_r;
        end
    end

    always_comb
    begin
        stat_w = 8'h00;
        stat_w[`FAIL_SAFE_MONITOR_SECONDARY_OSC_READY_BIT] = secondary_osc_enable ? secr_s : 1'b1;
        stat_w[`FAIL_SAFE_MONITOR_STARTUP_TIMER_STATUS_BIT] = on_cfg;
        stat_w[`FAIL_SAFE_MONITOR_HFR_BIT] = hfr_s;
        stat_w[`FAIL_SAFE_MONITOR_LFR_BIT] = lfr_s;
        stat_w[`FAIL_SAFE_MONITOR_HFS_BIT] = hfs_s;
    end

    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                `FAIL_SAFE_MONITOR_OFS_CTRL: reg_rdata <= {1'b0, ircf_r, 1'b0, scs_r};
                `FAIL_SAFE_MONITOR_OFS_STAT: reg_rdata <= stat_w;
                `FAIL_SAFE_MONITOR_OFS_IEN: reg_rdata <= {fail_ie_r, 7'h00};
                `FAIL_SAFE_MONITOR_OFS_IFLG: reg_rdata <= {fail_flag_r, 7'h00};
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

    property p_no_fail_in_ost;
        @(posedge mclk) disable iff (!arst_n) st_r == FAIL_SAFE_MONITOR_ST_OST |-> !fail_det;
    endproperty
    a_no_fail_in_ost: assert property (p_no_fail_in_ost) else $error("failure seen during start-up");

    property p_fail_sets_flag;
        @(posedge mclk) disable iff (!arst_n) fail_det |=> fail_flag_r && st_r == FAIL_SAFE_MONITOR_ST_FAIL;
    endproperty
    a_fail_sets_flag: assert property (p_fail_sets_flag) else $error("failure did not set flag");

    property p_irq;
        @(posedge mclk) disable iff (!arst_n) fail_flag_r && fail_ie_r |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt missing");

    property p_irq_quiet;
        @(posedge mclk) disable iff (!arst_n) !(fail_flag_r && fail_ie_r) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without flag");

    property p_fail_internal;
        @(posedge mclk) disable iff (!arst_n) st_r == FAIL_SAFE_MONITOR_ST_FAIL |=> !sys_on_ext;
    endproperty
    a_fail_internal: assert property (p_fail_internal) else $error("external clock used after failure");

    property p_scs_restart;
        @(posedge mclk) disable iff (!arst_n) scs_change && scs_new == 2'h0 && crystal |=> st_r == FAIL_SAFE_MONITOR_ST_OST;
    endproperty
    a_scs_restart: assert property (p_scs_restart) else $error("timer not restarted");

    property p_det_gated;
        @(posedge mclk) disable iff (!arst_n) !fail_monitor_enable_cfg |-> !fail_det;
    endproperty
    a_det_gated: assert property (p_det_gated) else $error("detector ran while disabled");

    property p_freq_out;
        @(posedge mclk) disable iff (!arst_n) wr_ctrl |=> ##1 int_freq_sel == $past(reg_wdata[6:3], 2);
    endproperty
    a_freq_out: assert property (p_freq_out) else $error("frequency select not applied");

    property p_startup_timer_status;
        @(posedge mclk) disable iff (!arst_n) reg_rd && reg_addr == `FAIL_SAFE_MONITOR_OFS_STAT |=> reg_rdata[5] == $past(on_cfg);
    endproperty
    a_startup_timer_status: assert property (p_startup_timer_status) else $error("start-up status wrong");

    property p_reserved;
        @(posedge mclk) disable iff (!arst_n) reg_rd && reg_addr == `FAIL_SAFE_MONITOR_OFS_CTRL
            |=> reg_rdata[7] == 1'b0 && reg_rdata[2] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit nonzero");
endmodule
`default_nettype wire

// >>> test/fail_safe_monitor_osc_model.sv
/*
 Far-side oscillators: external clock, low-frequency internal and secondary oscillator levels.
 Assumes the bench stops the external clock through run; a dead clock sits high.
*/
`default_nettype none
module fail_safe_monitor_osc_model
(
    input wire logic run,
    output logic ext_clk_pin,
    output logic lf_osc_pin,
    output logic sec_osc_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        ext_clk_pin = 1'b1;
        lf_osc_pin = 1'b0;
        sec_osc_pin = 1'b0;
    end
    // Periods are whole multiples of the 10 ns mclk period, so edges keep a fixed phase to the sampling point
    always #20 lf_osc_pin = ~lf_osc_pin;
    always #35 ext_clk_pin = run ? ~ext_clk_pin : 1'b1;
    always #150 sec_osc_pin = ~sec_osc_pin;
endmodule
`default_nettype wire

// >>> test/fail_safe_monitor_test.sv
/*
 Self-checking bench for the fail-safe clock monitor.
 Assumes fail_safe_monitor_defines.svh on the include path and a short start-up count.
*/
`include "fail_safe_monitor_defines.svh"
`default_nettype none
module fail_safe_monitor_test;
    timeunit 1ns;
    timeprecision 100ps;
    import fail_safe_monitor_pkg::*;
    logic mclk, arst_n, reg_wr, reg_rd, sleep_exec, ext_run, mon_en, sec_en;
    logic hf_rdy, lf_rdy, hf_stb, sec_rdy, sys_on_ext, sys_on_sec, irq;
    logic ext_clk_pin, lf_osc_pin, sec_osc_pin;
    logic [1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d, w;
    logic [3:0] int_freq_sel;
    fail_safe_monitor_mode_t mode;
    int bad_count, compares, seed, cycles;

    always #5 mclk = ~mclk;

    fail_safe_monitor_osc_model partner(.run(ext_run), .ext_clk_pin(ext_clk_pin), .lf_osc_pin(lf_osc_pin),
        .sec_osc_pin(sec_osc_pin));

    // Small start-up count keeps each switch-over short
    fail_safe_monitor_top #(.OST_CYCLES(4)) DUT(.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_mode_cfg(mode),
        .fail_monitor_enable_cfg(mon_en), .sleep_exec(sleep_exec), .ext_clk_pin(ext_clk_pin),
        .lf_osc_pin(lf_osc_pin), .sec_osc_pin(sec_osc_pin), .secondary_osc_enable(sec_en),
        .hf_ready_pin(hf_rdy), .lf_ready_pin(lf_rdy), .hf_stable_pin(hf_stb), .sec_ready_pin(sec_rdy),
        .sys_on_ext(sys_on_ext), .sys_on_sec(sys_on_sec), .int_freq_sel(int_freq_sel), .irq(irq));

    task summarize;
        $display("mismatches %0d comparisons %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            bad_count++;
            summarize();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Bounded wait for the system clock source to settle on the wanted side
    task wait_ext(input logic want, input int lim);
        int n;
        n = 0;
        while (sys_on_ext !== want && n < lim)
        begin
            @(posedge mclk);
            n++;
        end
        #1 chk({7'h00, sys_on_ext}, {7'h00, want});
    endtask

    function logic [7:0] stat_exp(input logic startup_timer_status);
        return {sec_en ? sec_rdy : 1'b1, 1'b0, startup_timer_status, hf_rdy, 2'b00, lf_rdy, hf_stb};
    endfunction

    initial
    begin
        mclk = 0; arst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0;
        sleep_exec = 0; ext_run = 1; mon_en = 1; sec_en = 0; mode = FAIL_SAFE_MONITOR_XT;
        hf_rdy = 1; lf_rdy = 1; hf_stb = 1; sec_rdy = 1; seed = 50;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`FAIL_SAFE_MONITOR_OFS_CTRL, d);
        chk(d, 8'h38);
        chk({4'h0, int_freq_sel}, 8'h07);
        chk({5'h00, irq, sys_on_ext, sys_on_sec}, 8'h00);
        repeat (8)
        begin
            w = $random(seed);
            w[1] = 1'b1;
            wr(`FAIL_SAFE_MONITOR_OFS_CTRL, w);
            rd(`FAIL_SAFE_MONITOR_OFS_CTRL, d);
            chk(d, w & 8'h7B);
            chk({4'h0, int_freq_sel}, {4'h0, w[6:3]});
            chk({6'h00, sys_on_ext, sys_on_sec}, 8'h00);
        end
        repeat (8)
        begin
            w = $random(seed);
            @(posedge mclk);
            {sec_en, sec_rdy, hf_rdy, lf_rdy, hf_stb} <= w[4:0];
            repeat (3) @(posedge mclk);
            rd(`FAIL_SAFE_MONITOR_OFS_STAT, d);
            chk(d, stat_exp(1'b0));
        end
        @(posedge mclk);
        {sec_en, sec_rdy, hf_rdy, lf_rdy, hf_stb} <= 5'h1F;
        wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h39);
        // Secondary select runs the start-up count first
        repeat (60) @(posedge mclk);
        chk({7'h00, sys_on_sec}, 8'h01);
        wr(`FAIL_SAFE_MONITOR_OFS_IEN, 8'h80);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge mclk);
            mode <= fail_safe_monitor_mode_t'(i);
            ext_run <= 1'b1;
            // Odd passes restart through sleep, even ones through a select change
            if (i % 2)
            begin
                wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h38);
                @(posedge mclk);
                sleep_exec <= 1'b1;
                @(posedge mclk);
                sleep_exec <= 1'b0;
            end
            else
            begin
                wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h3A);
                wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h38);
            end
            #1;
            if (i < 3)
                chk({7'h00, sys_on_ext}, 8'h00);
            wait_ext(1'b1, i < 3 ? 300 : 20);
            rd(`FAIL_SAFE_MONITOR_OFS_STAT, d);
            chk(d & 8'h20, 8'h20);
            @(posedge mclk);
            ext_run <= 1'b0;
            wait_ext(1'b0, 1000);
            rd(`FAIL_SAFE_MONITOR_OFS_IFLG, d);
            chk(d & 8'h80, 8'h80);
            chk({7'h00, irq}, 8'h01);
            chk({4'h0, int_freq_sel}, 8'h07);
            ext_run <= 1'b1;
            repeat (200) @(posedge mclk);
            chk({7'h00, sys_on_ext}, 8'h00);
            wr(`FAIL_SAFE_MONITOR_OFS_IFLG, 8'h00);
            repeat (2) @(posedge mclk);
            chk({7'h00, irq}, 8'h00);
        end
        ext_run <= 1'b0;
        mode <= FAIL_SAFE_MONITOR_XT;
        wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h3A);
        wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h38);
        repeat (600) @(posedge mclk);
        rd(`FAIL_SAFE_MONITOR_OFS_IFLG, d);
        chk(d, 8'h00);
        chk({7'h00, sys_on_ext}, 8'h00);
        mon_en <= 1'b0;
        ext_run <= 1'b1;
        wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h3A);
        wr(`FAIL_SAFE_MONITOR_OFS_CTRL, 8'h38);
        wait_ext(1'b1, 300);
        ext_run <= 1'b0;
        repeat (600) @(posedge mclk);
        rd(`FAIL_SAFE_MONITOR_OFS_IFLG, d);
        chk(d, 8'h00);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        rd(`FAIL_SAFE_MONITOR_OFS_CTRL, d);
        chk(d, 8'h38);
        chk({7'h00, sys_on_ext}, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
